/* File: src/ptp_capture.v */
// input timestamp capture for one general-purpose pin
`timescale 1ns/100ps
`default_nettype none
module ptp_capture #(
    parameter TW = 62
) (
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire pin,
    input wire falling,
    input wire [TW-1:0] time_now,
    output reg [TW-1:0] stamp_q,
    output reg hit_q
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    wire edge_seen;

    // ===================================================
    // synchroniser, edge pick and latch
    assign edge_seen = falling ? (s3_q & ~s2_q) : (~s3_q & s2_q);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            stamp_q <= {TW{1'b0}};
            hit_q <= 1'b0;
        end else if (ce) begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            hit_q <= edge_seen;
            if (edge_seen) begin
                stamp_q <= time_now;
            end
        end
    end
endmodule
`default_nettype wire

/* File: src/ptp_consts.vh */
// constants shared by the precision time unit: register map, fields, codes
`ifndef PTP_CONSTS_VH
`define PTP_CONSTS_VH
// ===================================================
// register byte offsets
`define REG_CTRL 8'h00
`define REG_INC_NS 8'h04
`define REG_INC_FRAC 8'h08
`define REG_TIME_SEC 8'h0C
`define REG_TIME_NS 8'h10
`define REG_TIME_FRAC 8'h14
`define REG_ING_ADJ 8'h18
`define REG_EGR_ADJ 8'h1C
`define REG_TRG0_SEC 8'h20
`define REG_TRG0_NS 8'h24
`define REG_TRG1_SEC 8'h28
`define REG_TRG1_NS 8'h2C
`define REG_TRG_CFG 8'h30
`define REG_TRG_PERIOD 8'h34
`define REG_TRG_PATTERN 8'h38
`define REG_CAP0_SEC 8'h3C
`define REG_CAP0_NS 8'h40
`define REG_CAP1_SEC 8'h44
`define REG_CAP1_NS 8'h48
`define REG_INT_STAT 8'h4C
`define REG_INT_MASK 8'h50
`define REG_LINK_DLY 8'h54
`define REG_ING_TS 8'h58
`define REG_EGR_TS 8'h5C
// ===================================================
// control register fields
`define CTRL_PTP_EN 0
`define CTRL_DET_EN 1
`define CTRL_P2P 2
`define CTRL_MASTER 3
`define CTRL_TWO_STEP 4
`define CTRL_DOM_CHK 5
`define CTRL_UDP4_ZERO 6
`define CTRL_HOST_FILT 7
`define CTRL_LOAD 8
`define CTRL_SNAP 9
`define CTRL_CAP0_FALL 10
`define CTRL_CAP1_FALL 11
`define CTRL_RESET 32'h0000_0000
// ===================================================
// time counter
`define NS_PER_SEC 30'h3B9ACA00
`define INC_NS_RESET 8'h05
`define INC_FRAC_RESET 32'h0000_0000
// ===================================================
// trigger modes, transports, message types, checksum actions
`define TRG_OFF 2'h0
`define TRG_PULSE 2'h1
`define TRG_CLOCK 2'h2
`define TRG_BITS 2'h3
`define TP_NONE 2'h0
`define TP_ETH 2'h1
`define TP_IPV4 2'h2
`define TP_IPV6 2'h3
`define MSG_SYNC 4'h0
`define MSG_DLY_REQ 4'h1
`define MSG_PDLY_REQ 4'h2
`define MSG_PDLY_RESP 4'h3
`define MSG_FOLLOW_UP 4'h8
`define MSG_DLY_RESP 4'h9
`define MSG_PDLY_RFU 4'hA
`define CSUM_KEEP 2'h0
`define CSUM_RECALC 2'h1
`define CSUM_ZERO 2'h2
`endif

/* File: src/ptp_time_sync_unit.v */
// precision time unit: time counter, frame actions, triggers, captures, APB registers
// Overview of operation
// - software reads and writes a time counter with 2^-32 ns fraction.
// - seconds field keeps only the low 32 of the 48 protocol bits.
// - transparent clock is end-to-end or peer-to-peer; host clock master or slave.
// - one-step or two-step event handling is chosen by configuration.
// - frames get PTP treatment only with PTP mode and detection both on.
// - per-frame action depends on clock type, role, step mode and domain check.
// - capture ingress stamps, record egress, add residence and link delay, insert stamps.
// - IPv4 UDP egress checksum is recomputed or forced to zero by setting.
// - IPv6 UDP egress checksum is recomputed only for one-step egress event frames.
// - PTP over IPv4 UDP, IPv6 UDP and plain Ethernet is recognised.
// - multicast and unicast PTP messages are both handled.
// - unwanted PTP messages are filtered away from the host.
// - programmable delay adjustments are applied to timestamps.
// - trigger output fires when the time counter reaches target time.
// - an input edge latches the current time counter value.
// - trigger and capture events can each raise an interrupt.
// - triggers make a clock, pulses or serial pattern on either pin.
// - input capture exists on both general-purpose pins.
`timescale 1ns/100ps
`default_nettype none
`include "ptp_consts.vh"
module ptp_time_sync_unit #(
    parameter CW = 16,
    parameter PW = 16
) (
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [1:0] gpio_in,
    output wire [1:0] gpio_out,
    output reg [1:0] gpio_oe,
    input wire frm_valid,
    input wire frm_ingress,
    input wire [1:0] frm_transport,
    input wire [3:0] frm_msg_type,
    input wire [7:0] frm_domain,
    input wire frm_unicast,
    input wire frm_to_host,
    input wire [29:0] frm_rx_ts_ns,
    output reg act_valid,
    output reg act_ptp,
    output reg act_drop,
    output reg act_ts_insert,
    output reg [31:0] act_corr_add,
    output reg [1:0] act_csum,
    output reg [31:0] act_ts_sec,
    output reg [29:0] act_ts_ns,
    output reg irq
);
    // ===================================================
    // register storage
    reg [31:0] ctrl_q;
    reg [7:0] inc_ns_q;
    reg [31:0] inc_frac_q;
    reg [31:0] ld_sec_q;
    reg [29:0] ld_ns_q;
    reg [31:0] ld_frac_q;
    reg [31:0] snap_sec_q;
    reg [29:0] snap_ns_q;
    reg [31:0] snap_frac_q;
    reg [29:0] ing_adj_q;
    reg [29:0] egr_adj_q;
    reg [31:0] trg_sec_q [0:1];
    reg [29:0] trg_ns_q [0:1];
    reg [15:0] trg_cfg_q;
    reg [31:0] trg_period_q;
    reg [31:0] trg_pattern_q;
    reg [3:0] int_stat_q;
    reg [3:0] int_mask_q;
    reg [29:0] link_dly_q;
    reg [29:0] ing_rec_q;
    reg [29:0] egr_rec_q;
    reg [1:0] match_q;
    // time counter
    reg [31:0] sec_q;
    reg [29:0] ns_q;
    reg [31:0] frac_q;

    wire [61:0] time_now = {sec_q, ns_q};
    wire apb_wr = psel & penable & pready & pwrite;
    wire apb_go = psel & penable & ~pready;
    reg [31:0] rd_mux;
    reg rd_ok;

    // add two nanosecond values and wrap at one second
    function [29:0] ns_add;
        input [29:0] a;
        input [29:0] b;
        reg [30:0] s;
        begin
            s = {1'b0, a} + {1'b0, b};
            if (s >= {1'b0, `NS_PER_SEC}) begin
                s = s - {1'b0, `NS_PER_SEC};
            end
            ns_add = s[29:0];
        end
    endfunction

    // ===================================================
    // time counter with fractional increment
    wire [32:0] frac_sum = {1'b0, frac_q} + {1'b0, inc_frac_q};
    wire [30:0] ns_sum = {1'b0, ns_q} + {23'h000000, inc_ns_q} + {30'h00000000, frac_sum[32]};
    wire ns_wrap = ns_sum >= {1'b0, `NS_PER_SEC};
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_q <= 32'h0000_0000;
            ns_q <= 30'h0000_0000;
            frac_q <= 32'h0000_0000;
        end else if (ce) begin
            if (apb_wr && paddr == `REG_CTRL && pwdata[`CTRL_LOAD]) begin
                sec_q <= ld_sec_q;
                ns_q <= ld_ns_q;
                frac_q <= ld_frac_q;
            end else begin
                frac_q <= frac_sum[31:0];
                if (ns_wrap) begin
                    ns_q <= ns_sum[29:0] - `NS_PER_SEC;
                    sec_q <= sec_q + 32'h0000_0001;
                end else begin
                    ns_q <= ns_sum[29:0];
                end
            end
        end
    end

    // ===================================================
    // trigger generators and input captures, one per pin
    wire [1:0] trg_fired;
    wire [1:0] cap_hit;
    wire [61:0] cap_stamp [0:1];
    wire [1:0] match_now;
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : pin_gen
            assign match_now[g] = trg_cfg_q[8*g+2] &&
                {trg_sec_q[g], trg_ns_q[g]} <= time_now;
            ptp_trigger_gen #(.CW(CW), .PW(PW)) u_trg (
                .pclk(pclk),
                .presetn(presetn),
                .ce(ce),
                .en(trg_cfg_q[8*g+2]),
                .mode(trg_cfg_q[8*g+1:8*g]),
                .start(match_now[g] & ~match_q[g]),
                .period(trg_period_q[16*g+CW-1:16*g]),
                .pattern(trg_pattern_q[16*g+PW-1:16*g]),
                .pin_q(gpio_out[g]),
                .fired_q(trg_fired[g])
            );
            ptp_capture #(.TW(62)) u_cap (
                .pclk(pclk),
                .presetn(presetn),
                .ce(ce),
                .pin(gpio_in[g]),
                .falling(ctrl_q[`CTRL_CAP0_FALL+g]),
                .time_now(time_now),
                .stamp_q(cap_stamp[g]),
                .hit_q(cap_hit[g])
            );
        end
    endgenerate

    // ===================================================
    // frame classification and editing decision
    wire ptp_on = ctrl_q[`CTRL_PTP_EN] & ctrl_q[`CTRL_DET_EN];
    wire is_ptp = ptp_on && frm_transport != `TP_NONE;
    wire dom_ok = ~ctrl_q[`CTRL_DOM_CHK] || frm_domain == ctrl_q[31:24];
    wire is_pdly = frm_msg_type == `MSG_PDLY_REQ || frm_msg_type == `MSG_PDLY_RESP ||
        frm_msg_type == `MSG_PDLY_RFU;
    wire is_e2e_dly = frm_msg_type == `MSG_DLY_REQ || frm_msg_type == `MSG_DLY_RESP;
    wire is_event = ~frm_msg_type[3];
    wire wrong_tc = ctrl_q[`CTRL_P2P] ? is_e2e_dly : is_pdly;
    wire host_unwanted = frm_to_host & ctrl_q[`CTRL_HOST_FILT] & (ctrl_q[`CTRL_MASTER] ?
        (frm_msg_type == `MSG_SYNC || frm_msg_type == `MSG_FOLLOW_UP) :
        frm_msg_type == `MSG_DLY_REQ);
    wire one_step = ~ctrl_q[`CTRL_TWO_STEP];
    wire [29:0] ing_stamp = ns_add(ns_q, ing_adj_q);
    wire [29:0] egr_stamp = ns_add(ns_q, egr_adj_q);
    wire [30:0] res_diff = {1'b0, egr_stamp} - {1'b0, frm_rx_ts_ns};
    wire [29:0] residence = res_diff[30] ? res_diff[29:0] + `NS_PER_SEC : res_diff[29:0];
    wire add_link = ctrl_q[`CTRL_P2P] & (frm_msg_type == `MSG_SYNC);
    wire [29:0] corr = add_link ? ns_add(residence, link_dly_q) : residence;
    wire ins = one_step & ~frm_ingress & is_event & (frm_msg_type == `MSG_SYNC ||
        frm_msg_type == `MSG_PDLY_RESP);
    wire modified = ~frm_ingress & is_event & (one_step | ins);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_valid <= 1'b0;
            act_ptp <= 1'b0;
            act_drop <= 1'b0;
            act_ts_insert <= 1'b0;
            act_corr_add <= 32'h0000_0000;
            act_csum <= `CSUM_KEEP;
            act_ts_sec <= 32'h0000_0000;
            act_ts_ns <= 30'h0000_0000;
            ing_rec_q <= 30'h0000_0000;
            egr_rec_q <= 30'h0000_0000;
        end else if (ce) begin
            act_valid <= frm_valid;
            if (frm_valid) begin
                // unicast and multicast frames take the same path
                act_ptp <= is_ptp;
                act_drop <= is_ptp & (~dom_ok | wrong_tc | host_unwanted);
                act_ts_insert <= is_ptp & ins;
                act_corr_add <= (is_ptp & modified & one_step) ? {2'h0, corr} : 32'h0000_0000;
                act_ts_sec <= sec_q;
                act_ts_ns <= frm_ingress ? ing_stamp : egr_stamp;
                if (is_ptp && frm_ingress && is_event) begin
                    ing_rec_q <= ing_stamp;
                end
                if (is_ptp && !frm_ingress && is_event && !one_step) begin
                    egr_rec_q <= egr_stamp;
                end
                if (!is_ptp || !modified || frm_transport == `TP_ETH) begin
                    act_csum <= `CSUM_KEEP;
                end else if (frm_transport == `TP_IPV6) begin
                    act_csum <= `CSUM_RECALC;
                end else begin
                    act_csum <= ctrl_q[`CTRL_UDP4_ZERO] ? `CSUM_ZERO : `CSUM_RECALC;
                end
            end
        end
    end

    // ===================================================
    // register writes, snapshot, sticky interrupt status
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `CTRL_RESET;
            inc_ns_q <= `INC_NS_RESET;
            inc_frac_q <= `INC_FRAC_RESET;
            ld_sec_q <= 32'h0000_0000;
            ld_ns_q <= 30'h0000_0000;
            ld_frac_q <= 32'h0000_0000;
            snap_sec_q <= 32'h0000_0000;
            snap_ns_q <= 30'h0000_0000;
            snap_frac_q <= 32'h0000_0000;
            ing_adj_q <= 30'h0000_0000;
            egr_adj_q <= 30'h0000_0000;
            trg_sec_q[0] <= 32'h0000_0000;
            trg_sec_q[1] <= 32'h0000_0000;
            trg_ns_q[0] <= 30'h0000_0000;
            trg_ns_q[1] <= 30'h0000_0000;
            trg_cfg_q <= 16'h0000;
            trg_period_q <= 32'h0000_0000;
            trg_pattern_q <= 32'h0000_0000;
            int_stat_q <= 4'h0;
            int_mask_q <= 4'h0;
            link_dly_q <= 30'h0000_0000;
            match_q <= 2'h0;
            gpio_oe <= 2'h0;
            irq <= 1'b0;
        end else if (ce) begin
            match_q <= match_now;
            gpio_oe <= {trg_cfg_q[10], trg_cfg_q[2]};
            irq <= |(int_stat_q & int_mask_q);
            if (apb_wr) begin
                case (paddr)
                    `REG_CTRL: begin
                        ctrl_q <= {pwdata[31:10], 2'b00, pwdata[7:0]};
                        if (pwdata[`CTRL_SNAP]) begin
                            snap_sec_q <= sec_q;
                            snap_ns_q <= ns_q;
                            snap_frac_q <= frac_q;
                        end
                    end
                    `REG_INC_NS: inc_ns_q <= pwdata[7:0];
                    `REG_INC_FRAC: inc_frac_q <= pwdata;
                    `REG_TIME_SEC: ld_sec_q <= pwdata;
                    `REG_TIME_NS: ld_ns_q <= pwdata[29:0];
                    `REG_TIME_FRAC: ld_frac_q <= pwdata;
                    `REG_ING_ADJ: ing_adj_q <= pwdata[29:0];
                    `REG_EGR_ADJ: egr_adj_q <= pwdata[29:0];
                    `REG_TRG0_SEC: trg_sec_q[0] <= pwdata;
                    `REG_TRG0_NS: trg_ns_q[0] <= pwdata[29:0];
                    `REG_TRG1_SEC: trg_sec_q[1] <= pwdata;
                    `REG_TRG1_NS: trg_ns_q[1] <= pwdata[29:0];
                    `REG_TRG_CFG: trg_cfg_q <= pwdata[15:0];
                    `REG_TRG_PERIOD: trg_period_q <= pwdata;
                    `REG_TRG_PATTERN: trg_pattern_q <= pwdata;
                    `REG_INT_MASK: int_mask_q <= pwdata[3:0];
                    `REG_LINK_DLY: link_dly_q <= pwdata[29:0];
                    default: begin
                    end
                endcase
            end
            // write one to clear, a new event in the same cycle wins
            int_stat_q <= (int_stat_q & ~((apb_wr && paddr == `REG_INT_STAT) ?
                pwdata[3:0] : 4'h0)) | {cap_hit, trg_fired};
        end
    end

    // ===================================================
    // read decode
    always @* begin
        rd_ok = 1'b1;
        case (paddr)
            `REG_CTRL: rd_mux = ctrl_q;
            `REG_INC_NS: rd_mux = {24'h000000, inc_ns_q};
            `REG_INC_FRAC: rd_mux = inc_frac_q;
            `REG_TIME_SEC: rd_mux = snap_sec_q;
            `REG_TIME_NS: rd_mux = {2'h0, snap_ns_q};
            `REG_TIME_FRAC: rd_mux = snap_frac_q;
            `REG_ING_ADJ: rd_mux = {2'h0, ing_adj_q};
            `REG_EGR_ADJ: rd_mux = {2'h0, egr_adj_q};
            `REG_TRG0_SEC: rd_mux = trg_sec_q[0];
            `REG_TRG0_NS: rd_mux = {2'h0, trg_ns_q[0]};
            `REG_TRG1_SEC: rd_mux = trg_sec_q[1];
            `REG_TRG1_NS: rd_mux = {2'h0, trg_ns_q[1]};
            `REG_TRG_CFG: rd_mux = {16'h0000, trg_cfg_q};
            `REG_TRG_PERIOD: rd_mux = trg_period_q;
            `REG_TRG_PATTERN: rd_mux = trg_pattern_q;
            `REG_CAP0_SEC: rd_mux = cap_stamp[0][61:30];
            `REG_CAP0_NS: rd_mux = {2'h0, cap_stamp[0][29:0]};
            `REG_CAP1_SEC: rd_mux = cap_stamp[1][61:30];
            `REG_CAP1_NS: rd_mux = {2'h0, cap_stamp[1][29:0]};
            `REG_INT_STAT: rd_mux = {28'h0000000, int_stat_q};
            `REG_INT_MASK: rd_mux = {28'h0000000, int_mask_q};
            `REG_LINK_DLY: rd_mux = {2'h0, link_dly_q};
            `REG_ING_TS: rd_mux = {2'h0, ing_rec_q};
            `REG_EGR_TS: rd_mux = {2'h0, egr_rec_q};
            default: begin
                rd_mux = 32'h0000_0000;
                rd_ok = 1'b0;
            end
        endcase
    end

    // ===================================================
    // APB answer: one wait state, then ready with data and error
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= apb_go;
            if (apb_go) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr <= ~rd_ok;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: src/ptp_trigger_gen.v */
// trigger output generator for one general-purpose pin
`timescale 1ns/100ps
`default_nettype none
`include "ptp_consts.vh"
module ptp_trigger_gen #(
    parameter CW = 16,
    parameter PW = 16
) (
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire en,
    input wire [1:0] mode,
    input wire start,
    input wire [CW-1:0] period,
    input wire [PW-1:0] pattern,
    output reg pin_q,
    output reg fired_q
);
    reg run_q;
    reg [CW-1:0] cnt_q;
    reg [4:0] idx_q;

    // ===================================================
    // pulse, clock or serial pattern timed from the start event
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= 1'b0;
            cnt_q <= {CW{1'b0}};
            idx_q <= 5'h00;
            pin_q <= 1'b0;
            fired_q <= 1'b0;
        end else if (ce) begin
            fired_q <= 1'b0;
            if (!en || mode == `TRG_OFF) begin
                run_q <= 1'b0;
                pin_q <= 1'b0;
            end else if (start) begin
                run_q <= 1'b1;
                fired_q <= 1'b1;
                cnt_q <= period;
                idx_q <= 5'h01;
                pin_q <= (mode == `TRG_BITS) ? pattern[0] : 1'b1;
            end else if (run_q) begin
                if (cnt_q > {{(CW-1){1'b0}}, 1'b1}) begin
                    cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
                end else begin
                    cnt_q <= period;
                    case (mode)
                        `TRG_PULSE: begin
                            run_q <= 1'b0;
                            pin_q <= 1'b0;
                        end
                        `TRG_CLOCK: begin
                            pin_q <= ~pin_q;
                        end
                        default: begin
                            if (idx_q == PW) begin
                                run_q <= 1'b0;
                                pin_q <= 1'b0;
                            end else begin
                                pin_q <= pattern[idx_q[3:0]];
                                idx_q <= idx_q + 5'h01;
                            end
                        end
                    endcase
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: testbench/ptp_link_partner.sv */
// far-side model: frame descriptors from link partners and pin edges
`timescale 1ns/100ps
`default_nettype none
module ptp_link_partner (
    input wire logic pclk,
    output logic frm_valid,
    output logic frm_ingress,
    output logic [1:0] frm_transport,
    output logic [3:0] frm_msg_type,
    output logic [7:0] frm_domain,
    output logic frm_unicast,
    output logic frm_to_host,
    output logic [29:0] frm_rx_ts_ns,
    output logic [1:0] gpio_in
);
// quiet lines at time zero
initial begin
    {frm_valid, frm_ingress, frm_transport, frm_msg_type, frm_domain} = 0;
    {frm_unicast, frm_to_host, frm_rx_ts_ns, gpio_in} = 0;
end
// one egress descriptor, then fields scrambled while idle
task send(input logic [1:0] tp, input logic [3:0] msg);
    @(posedge pclk);
    frm_valid <= 1'b1;
    frm_transport <= tp;
    frm_msg_type <= msg;
    frm_domain <= 8'($urandom);
    frm_unicast <= 1'($urandom);
    frm_rx_ts_ns <= 30'($urandom_range(0, 999999));
    @(posedge pclk);
    frm_valid <= 1'b0;
    frm_transport <= ~tp;
    frm_msg_type <= ~msg;
endtask
// rising edge on one pin
task pin_up(input int p);
    @(posedge pclk);
    gpio_in[p] <= 1'b1;
endtask
endmodule
`default_nettype wire

/* File: testbench/ptp_time_sync_unit_props.sv */
// port-level checks for the precision time unit
`timescale 1ns/100ps
`default_nettype none
`include "ptp_consts.vh"
module ptp_time_sync_unit_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic frm_valid,
    input wire logic frm_ingress,
    input wire logic [1:0] frm_transport,
    input wire logic act_valid,
    input wire logic act_ptp,
    input wire logic act_drop,
    input wire logic act_ts_insert,
    input wire logic [31:0] act_corr_add,
    input wire logic [1:0] act_csum,
    input wire logic [31:0] act_ts_sec,
    input wire logic [29:0] act_ts_ns,
    input wire logic [1:0] gpio_out,
    input wire logic [1:0] gpio_oe,
    input wire logic irq
);
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
// ==========
// register bus answers
property p_ans; psel && penable && !pready && ce |=> pready; endproperty
a_ans: assert property (p_ans) else $error("bus answer late");
property p_pulse; pready && ce |=> !pready; endproperty
a_pulse: assert property (p_pulse) else $error("ready too long");
property p_idle; !psel |-> !pready; endproperty
a_idle: assert property (p_idle) else $error("ready without select");
property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
a_err: assert property (p_err) else $error("bad error answer");
property p_wr; pready && pwrite |-> prdata == 32'h0; endproperty
a_wr: assert property (p_wr) else $error("write returned data");
// ==========
// frame actions
property p_act; frm_valid && ce |=> act_valid; endproperty
a_act: assert property (p_act) else $error("no frame action");
property p_src; act_valid |-> $past(frm_valid); endproperty
a_src: assert property (p_src) else $error("action without frame");
property p_plain; act_valid && !act_ptp |-> act_corr_add == 32'h0 && act_csum == `CSUM_KEEP;
endproperty
a_plain: assert property (p_plain) else $error("plain frame edited");
property p_hold; !act_valid |-> $stable(act_ts_sec) && $stable(act_ts_ns) && $stable(act_corr_add);
endproperty
a_hold: assert property (p_hold) else $error("action fields moved");
property p_v6; act_valid && act_ptp && !act_drop && act_ts_insert && $past(frm_valid)
    && $past(frm_transport) == `TP_IPV6 && !$past(frm_ingress) |-> act_csum == `CSUM_RECALC;
endproperty
a_v6: assert property (p_v6) else $error("ipv6 checksum kept");
// a trigger pin only toggles while its output enable is on
property p_pin; (gpio_out & ~gpio_oe) == 2'h0; endproperty
a_pin: assert property (p_pin) else $error("pin driven while released");
c_err: cover property (pslverr);
c_zero: cover property (act_valid && act_csum == `CSUM_ZERO);
c_irq: cover property (irq);
endmodule
bind ptp_time_sync_unit ptp_time_sync_unit_props chk_u (.*);
`default_nettype wire

/* File: testbench/ptp_time_sync_unit_test.sv */
// self-checking bench for the precision time unit
`timescale 1ns/100ps
`default_nettype none
`include "ptp_consts.vh"
module ptp_time_sync_unit_test;
logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq;
logic act_valid, act_ptp, act_drop, act_ts_insert, frm_valid, frm_ingress, frm_unicast;
logic frm_to_host;
logic [7:0] paddr, frm_domain;
logic [31:0] pwdata, prdata, act_corr_add, act_ts_sec, fr;
logic [1:0] gpio_in, gpio_out, gpio_oe, frm_transport, act_csum;
logic [3:0] frm_msg_type;
logic [29:0] frm_rx_ts_ns, act_ts_ns;
logic [32:0] rd_q[$];
logic [3:0] act_q[$];
int error_cnt, tests_run;
ptp_time_sync_unit dut_u (.*);
ptp_link_partner pm (.*);
// clock
initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
end
// compare and count
task chk(input string n, input logic [32:0] s, input logic [32:0] e);
    tests_run++;
    if (s !== e) begin
        error_cnt++;
        $display("wrong value %s expected %h seen %h", n, e, s);
    end
endtask
// apb transfer, held until ready is sampled
task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (!pready);
    psel <= 0;
    penable <= 0;
endtask
task rd(input logic [7:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    apb(0, a, 32'h0);
endtask
task frm(input logic [1:0] tp, input logic [3:0] e, input logic [3:0] m = `MSG_SYNC);
    act_q.push_back(e);
    pm.send(tp, m);
endtask
// result watcher takes the oldest note
always @(posedge pclk) begin
    if (psel && pready && !pwrite && rd_q.size() > 0)
        chk("read", {pslverr, prdata}, rd_q.pop_front());
    if (act_valid && act_q.size() > 0)
        chk("action", {act_ptp, act_drop, act_csum}, act_q.pop_front());
end
task end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
endtask
// hang guard
initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    $display("timeout reached");
    end_of_test;
end
// main sequence
initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
    ce = 1;
    void'($urandom(32'h4cb3109d));
    repeat (3) @(posedge pclk);
    presetn <= 1;
    rd(`REG_CTRL, 33'h0);
    rd(`REG_INC_NS, 33'h5);
    rd(8'hFC, 33'h1_0000_0000);
    $display("test registers done");
    fr = $urandom;
    apb(1, `REG_TIME_SEC, 32'h1234);
    apb(1, `REG_TIME_NS, 32'h0);
    apb(1, `REG_TIME_FRAC, fr);
    apb(1, `REG_CTRL, 32'h100);
    // clock enable low freezes the counter between load and snapshot
    ce <= 0;
    repeat (4) @(posedge pclk);
    ce <= 1;
    apb(1, `REG_CTRL, 32'h200);
    rd(`REG_TIME_SEC, 33'h1234);
    rd(`REG_TIME_NS, 33'hF);
    rd(`REG_TIME_FRAC, {1'b0, fr});
    $display("test time done");
    frm(`TP_IPV4, {2'b00, `CSUM_KEEP});
    apb(1, `REG_CTRL, 32'h1);
    frm(`TP_IPV6, {2'b00, `CSUM_KEEP});
    for (int z = 0; z < 2; z++) begin
        apb(1, `REG_CTRL, z ? 32'h47 : 32'h3);
        frm(`TP_ETH, {2'b10, `CSUM_KEEP});
        frm(`TP_ETH, {1'b1, z == 0, `CSUM_KEEP}, `MSG_PDLY_REQ);
        frm(`TP_IPV4, {2'b10, z ? `CSUM_ZERO : `CSUM_RECALC});
        frm(`TP_IPV6, {2'b10, `CSUM_RECALC});
    end
    $display("test frames done");
    apb(1, `REG_INT_MASK, 32'h5);
    apb(1, `REG_TRG_PERIOD, 32'h4);
    apb(1, `REG_TRG_CFG, 32'h5);
    pm.pin_up(0);
    @(posedge pclk);
    chk("pin", {32'h0, gpio_out[0]}, 33'h1);
    repeat (20) @(posedge pclk);
    chk("pin", {32'h0, gpio_out[0]}, 33'h0);
    chk("oe", {32'h0, gpio_oe[0]}, 33'h1);
    chk("irq", {32'h0, irq}, 33'h1);
    rd(`REG_INT_STAT, 33'h5);
    rd(`REG_CAP0_SEC, 33'h1234);
    apb(1, `REG_INT_STAT, 32'h5);
    rd(`REG_INT_STAT, 33'h0);
    chk("irq", {32'h0, irq}, 33'h0);
    $display("test events done");
    end_of_test;
end
endmodule
`default_nettype wire
